// [design/rpc_pkg.sv]
/*
 * constants, types and helpers shared by the reset and power-mode control block.
 * assumes a single 25 MHz system clock and an asynchronous active-low reset.
 */
// What this block does
// - writing one to reset-control bit 4 resets the filter and converter modules
// - that module reset also resets the processing core, restarting it
// - module-reset bit clears itself when done; accepted only in standby or powerdown
// - writing one to reset-control bit 0 returns mode registers to defaults
// - register reset leaves internal memory untouched
// - register-reset bit clears itself; only issued while in standby or powerdown
// - standby bit 4 of power register forces system standby, as errors do
// - system standby powers down all but charge pump and digital supply
// - powerdown bit 0 forces powerdown, removing power from retained blocks too
// - powerdown wins when both powerdown and standby are requested
package rpc_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] RPC_RST_CTL_ADDR = 8'h01;
    localparam logic [7:0] RPC_PWR_REQ_ADDR = 8'h02;
    localparam int unsigned RPC_MOD_RST_BIT = 4;
    localparam int unsigned RPC_REG_RST_BIT = 0;
    localparam int unsigned RPC_STBY_BIT    = 4;
    localparam int unsigned RPC_PDN_BIT     = 0;
    localparam logic [7:0] RPC_RST_CTL_RST  = 8'h00;
    localparam logic [7:0] RPC_PWR_REQ_RST  = 8'h00;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned RPC_CLK_PERIOD_NS = 40;
    localparam int unsigned RPC_MOD_RST_NS    = 1000;
    // least time, so round up
    localparam int unsigned RPC_MOD_RST_CYC   =
        (RPC_MOD_RST_NS + RPC_CLK_PERIOD_NS - 1) / RPC_CLK_PERIOD_NS;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        RPC_RUN  = 2'b00,
        RPC_STBY = 2'b01,
        RPC_PDN  = 2'b10
    } rpc_pwr_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rpc_reg_req_s;

    typedef struct packed {
        logic core_en;
        logic cp_en;
        logic dig_en;
    } rpc_pwr_s;

    // supply enables out of reset: the block wakes up running
    localparam rpc_pwr_s RPC_PWR_RST = 3'b111;

    // standby and powerdown both count as low power for reset requests
    function automatic logic rpc_low_power(input rpc_pwr_e st);
        rpc_low_power = (st != RPC_RUN);
    endfunction : rpc_low_power

    // supply enables for a given power state
    function automatic rpc_pwr_s rpc_pwr_of(input rpc_pwr_e st);
        rpc_pwr_of.core_en = (st == RPC_RUN);
        rpc_pwr_of.cp_en   = (st != RPC_PDN);
        rpc_pwr_of.dig_en  = (st != RPC_PDN);
    endfunction : rpc_pwr_of

endpackage : rpc_pkg

// [design/rpc_pulse_seq.sv]
/*
 * fixed-length reset pulse generator with busy flag.
 * assumes start is a same-clock request; starts while busy are ignored.
 */
`timescale 1ns/100ps
module rpc_pulse_seq #(
    parameter int unsigned CYC = rpc_pkg::RPC_MOD_RST_CYC
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // request and pulse
    input  wire logic start,
    output logic      busy
);
    import rpc_pkg::*;

    localparam int unsigned CW = $clog2(CYC + 1);

    typedef struct packed {
        logic          busy;
        logic [CW-1:0] cnt;
    } rpc_seq_s;

    rpc_seq_s st_r;
    rpc_seq_s st_nxt;

    // busy stays high for exactly CYC cycles
    always_comb begin
        st_nxt = st_r;
        if (st_r.busy) begin
            if (st_r.cnt == '0) begin
                st_nxt.busy = 1'b0;
            end else begin
                st_nxt.cnt = st_r.cnt - 1'b1;
            end
        end else if (start) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt  = CW'(CYC - 1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy = st_r.busy;

endmodule : rpc_pulse_seq

// [design/rpc_sync.sv]
/*
 * three-stage synchroniser for an asynchronous pin level.
 * assumes the pin may change at any time relative to ref_clk.
 */
`timescale 1ns/100ps
module rpc_sync (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // pin and result
    input  wire logic pin,
    output logic      level
);
    import rpc_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } rpc_sync_s;

    rpc_sync_s st_r;
    rpc_sync_s st_nxt;

    // first stage feeds only the second; change taken once stages two and three agree
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.lvl = st_r.s3;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.lvl;

endmodule : rpc_sync

// [design/rpc_top.sv]
/*
 * reset request and power-mode control: two control registers, module
 * reset pulse, mode-register reset pulse and power state machine, with
 * the assertions and covers that guard them beside the logic.
 * assumes a same-clock register port from the control-port decoder and an
 * asynchronous error pin from the protection logic; resets are honoured
 * only in standby or powerdown, so the host must enter one of those first.
 * the error pin is taken as a level: standby holds only while it is high.
 */
`timescale 1ns/100ps
module rpc_top (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // register port
    input  wire rpc_pkg::rpc_reg_req_s reg_req,
    output logic [7:0]               reg_rdata,
    // error pin
    input  wire logic                err_pin,
    // reset outputs
    output logic                     conv_rst,
    output logic                     dsp_rst,
    output logic                     mode_reg_rst,
    // power outputs
    output rpc_pkg::rpc_pwr_s        pwr,
    output rpc_pkg::rpc_pwr_e        pwr_state
);
    import rpc_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        rpc_pwr_e   st;
        logic       stby_req;
        logic       pdn_req;
        logic       mode_rst;
        logic [7:0] rdata;
        rpc_pwr_s   pwr;
    } rpc_top_s;

    rpc_top_s st_r;
    rpc_top_s st_nxt;
    logic     err_lvl;
    logic     mod_busy;
    logic     mod_start;
    logic     wr_rst;
    logic     wr_pwr;
    logic     low;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    rpc_sync rpc_sync_i (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin     (err_pin),
        .level   (err_lvl)
    );

    rpc_pulse_seq #(
        .CYC (RPC_MOD_RST_CYC)
    ) rpc_pulse_seq_i (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (mod_start),
        .busy    (mod_busy)
    );

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // one compare shared by the write strobes and the read mux
    function automatic logic rpc_sel(input logic [7:0] addr, input logic [7:0] base);
        rpc_sel = (addr == base);
    endfunction : rpc_sel

    // write decode
    always_comb begin
        wr_rst = 1'b0;
        wr_pwr = 1'b0;
        if (reg_req.wr && rpc_sel(reg_req.addr, RPC_RST_CTL_ADDR)) begin
            wr_rst = 1'b1;
        end else if (reg_req.wr && rpc_sel(reg_req.addr, RPC_PWR_REQ_ADDR)) begin
            wr_pwr = 1'b1;
        end
    end

    assign low = rpc_low_power(st_r.st);
    // running-mode requests are dropped, the bit never reads back set
    assign mod_start = wr_rst && low && reg_req.wdata[RPC_MOD_RST_BIT];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt          = st_r;
        st_nxt.mode_rst = 1'b0;
        if (wr_pwr) begin
            st_nxt.stby_req = reg_req.wdata[RPC_STBY_BIT];
            st_nxt.pdn_req  = reg_req.wdata[RPC_PDN_BIT];
        end
        // register reset restores defaults only; memory sees nothing
        if (wr_rst && low && reg_req.wdata[RPC_REG_RST_BIT]) begin
            st_nxt.stby_req = RPC_PWR_REQ_RST[RPC_STBY_BIT];
            st_nxt.pdn_req  = RPC_PWR_REQ_RST[RPC_PDN_BIT];
            st_nxt.mode_rst = 1'b1;
        end
        // read data; module-reset bit shows the running pulse
        if (reg_req.rd) begin
            if (rpc_sel(reg_req.addr, RPC_RST_CTL_ADDR)) begin
                st_nxt.rdata = RPC_RST_CTL_RST;
                st_nxt.rdata[RPC_MOD_RST_BIT] = mod_busy;
            end else if (rpc_sel(reg_req.addr, RPC_PWR_REQ_ADDR)) begin
                st_nxt.rdata = RPC_PWR_REQ_RST;
                st_nxt.rdata[RPC_STBY_BIT] = st_r.stby_req;
                st_nxt.rdata[RPC_PDN_BIT]  = st_r.pdn_req;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end
        // power state: powerdown first, then standby or error, else run
        case (1'b1)
            st_r.pdn_req: begin
                st_nxt.st = RPC_PDN;
            end
            st_r.stby_req, err_lvl: begin
                st_nxt.st = RPC_STBY;
            end
            default: begin
                st_nxt.st = RPC_RUN;
            end
        endcase
        st_nxt.pwr = rpc_pwr_of(st_nxt.st);
    end

    // state register; reset brings the block up running with all supplies on
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r          <= '0;
            st_r.st       <= RPC_RUN;
            st_r.pwr      <= RPC_PWR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata    = st_r.rdata;
    assign conv_rst     = mod_busy;
    assign dsp_rst      = mod_busy;
    assign mode_reg_rst = st_r.mode_rst;
    assign pwr          = st_r.pwr;
    assign pwr_state    = st_r.st;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // bound with some slack over the module reset pulse
    localparam int MOD_WAIT = 30;
    logic [7:0] hi_cnt;

    // length of the module reset pulse, only for checking
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt <= 8'h00;
        end else if (dsp_rst) begin
            hi_cnt <= hi_cnt + 8'h01;
        end else begin
            hi_cnt <= 8'h00;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // a module reset taken in low power starts both reset outputs
    mod_rst_start_a: assert property (
        (wr_rst && low && reg_req.wdata[RPC_MOD_RST_BIT] && !mod_busy)
            |=> conv_rst && dsp_rst)
        else $error("module reset not started");

    // the processing core reset never lags the converter reset
    dsp_with_conv_a: assert property (
        $rose(conv_rst) |-> $rose(dsp_rst) ##1 (dsp_rst && conv_rst))
        else $error("processing core reset not with converter reset");

    // a module reset written while running is dropped
    mod_rst_run_a: assert property (
        (wr_rst && !low && !mod_busy) |=> !conv_rst)
        else $error("module reset accepted while running");

    // the module reset bit clears itself
    mod_rst_clear_a: assert property (
        $rose(dsp_rst) |-> ##[1:MOD_WAIT] !dsp_rst)
        else $error("module reset bit never cleared");

    // the pulse lasts exactly the fixed reset time
    mod_rst_len_a: assert property (
        $fell(dsp_rst) |-> hi_cnt == 8'(RPC_MOD_RST_CYC))
        else $error("module reset pulse wrong length");

    // register reset puts the request register back to its defaults
    reg_rst_def_a: assert property (
        (wr_rst && low && reg_req.wdata[RPC_REG_RST_BIT])
            |=> mode_reg_rst && !st_r.stby_req && !st_r.pdn_req)
        else $error("register reset did not restore defaults");

    // register reset alone never reaches the memory side
    reg_rst_mem_a: assert property (
        (wr_rst && reg_req.wdata == 8'h01 && !mod_busy) |=> !dsp_rst)
        else $error("register reset touched memory side");

    // the register reset bit clears itself
    reg_rst_self_a: assert property (
        mode_reg_rst |=> !mode_reg_rst)
        else $error("register reset bit not self cleared");

    // a standby request alone gives standby supplies
    stby_enter_a: assert property (
        (st_r.stby_req && !st_r.pdn_req) |=> pwr_state == RPC_STBY
            && !pwr.core_en && pwr.cp_en && pwr.dig_en)
        else $error("standby not entered");

    // powerdown wins whatever else is requested
    pdn_prio_a: assert property (
        st_r.pdn_req |=> pwr_state == RPC_PDN && !pwr.cp_en && !pwr.dig_en)
        else $error("powerdown not entered");

    // nothing requested and no error: back to running
    run_resume_a: assert property (
        (!st_r.pdn_req && !st_r.stby_req && !err_lvl)
            |=> pwr_state == RPC_RUN && pwr.core_en)
        else $error("normal operation not resumed");

    // the reset register reads the running pulse, every other bit zero
    rd_busy_a: assert property (
        (reg_req.rd && reg_req.addr == RPC_RST_CTL_ADDR)
            |=> reg_rdata == {3'b000, $past(mod_busy), 4'h0})
        else $error("reset control read back wrong");

    // the power register reads back both stored requests
    rd_pwr_a: assert property (
        (reg_req.rd && reg_req.addr == RPC_PWR_REQ_ADDR)
            |=> reg_rdata == {3'b000, $past(st_r.stby_req), 3'b000, $past(st_r.pdn_req)})
        else $error("power request read back wrong");

    // read data only moves on a read strobe
    rd_hold_a: assert property (
        !reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    // a power write stores both request bits as written
    pwr_req_wr_a: assert property (
        wr_pwr |=> st_r.stby_req == $past(reg_req.wdata[RPC_STBY_BIT])
            && st_r.pdn_req == $past(reg_req.wdata[RPC_PDN_BIT]))
        else $error("power request write not stored");

    // module reset only ever starts from a low-power state
    mod_rst_low_a: assert property (
        $rose(conv_rst) |-> $past(low))
        else $error("module reset started while running");

    // register reset only ever fires from a low-power state
    reg_rst_low_a: assert property (
        mode_reg_rst |-> $past(low))
        else $error("register reset fired while running");

    // an error level alone still forces standby
    err_stby_a: assert property (
        (err_lvl && !st_r.pdn_req) |=> pwr_state == RPC_STBY)
        else $error("error did not force standby");

    // powerdown removes every supply
    pdn_off_a: assert property (
        pwr_state == RPC_PDN |-> !pwr.core_en && !pwr.cp_en && !pwr.dig_en)
        else $error("supply left on in powerdown");

    // standby keeps the charge pump and digital supply only
    stby_keep_a: assert property (
        pwr_state == RPC_STBY |-> !pwr.core_en && pwr.cp_en && pwr.dig_en)
        else $error("standby supplies wrong");

    // running keeps every supply on
    run_on_a: assert property (
        pwr_state == RPC_RUN |-> pwr.core_en && pwr.cp_en && pwr.dig_en)
        else $error("supply off while running");

    // cleared requests after a register reset let the block run again
    reg_rst_run_a: assert property (
        (mode_reg_rst && !err_lvl) |=> pwr_state == RPC_RUN)
        else $error("no return to run after register reset");

    // main scenarios
    mod_rst_c: cover property ($fell(dsp_rst));
    pdn_both_c: cover property (st_r.pdn_req && st_r.stby_req ##1 pwr_state == RPC_PDN);
    err_stby_c: cover property (err_lvl && !st_r.stby_req ##1 pwr_state == RPC_STBY);
    reg_rst_c: cover property (mode_reg_rst);
    rd_busy_c: cover property (reg_req.rd && reg_req.addr == RPC_RST_CTL_ADDR && mod_busy);

endmodule : rpc_top

// [verification/tb_top.sv]
/*
 * self-checking bench for the reset and power-mode control block.
 * assumes the block's same-clock register port; stimulus changes on the
 * falling edge so that every rising edge samples settled inputs.
 */
`timescale 1ns/100ps
module tb_top;
    import rpc_pkg::*;

    // ----------------------------------------
    // clock, reset and design hookup
    // ----------------------------------------
    logic         ref_clk;
    logic         rst_n;
    rpc_reg_req_s reg_req;
    logic [7:0]   reg_rdata;
    logic         err_pin;
    logic         conv_rst;
    logic         dsp_rst;
    logic         mode_reg_rst;
    rpc_pwr_s     pwr;
    rpc_pwr_e     pwr_state;
    int           miscompares;
    int           comparisons;
    int           conv_tot = 0;
    int           mode_tot = 0;

    rpc_top rpc_top_i (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .reg_req      (reg_req),
        .reg_rdata    (reg_rdata),
        .err_pin      (err_pin),
        .conv_rst     (conv_rst),
        .dsp_rst      (dsp_rst),
        .mode_reg_rst (mode_reg_rst),
        .pwr          (pwr),
        .pwr_state    (pwr_state)
    );

    // running totals of reset high cycles, sampled where outputs are settled
    always @(negedge ref_clk) begin
        if (conv_rst === 1'b1) begin
            conv_tot++;
        end
        if (mode_reg_rst === 1'b1) begin
            mode_tot++;
        end
    end

    // 25 MHz free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    // verdict lives here only, so every exit path prints it the same way
    task automatic results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : cmp

    // one-cycle write strobe, taken at the rising edge in between; the idle
    // cycle after it keeps two calls from touching the strobe in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk);
        reg_req.wr = 1'b0;
        @(negedge ref_clk);
    endtask : wr

    // read data is registered, so it is settled by the next falling edge
    task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge ref_clk);
        reg_req.rd = 1'b0;
        cmp(what, exp, reg_rdata);
        @(negedge ref_clk);
    endtask : rd

    // bounded wait for a power state, then check state and supply enables
    task automatic wait_pwr(input rpc_pwr_e exp, input logic [2:0] en);
        int n;
        n = 0;
        while (pwr_state !== exp && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        if (pwr_state !== exp) begin
            $display("Error pwr_state wait expected %h seen %h", exp, pwr_state);
            miscompares++;
            results();
        end else begin
            cmp("pwr_state", {6'h00, exp}, {6'h00, pwr_state});
            cmp("pwr", {5'h00, en}, {5'h00, pwr});
        end
    endtask : wait_pwr

    // watch 60 cycles; the totals give the high cycles since the snapshot,
    // so the count does not depend on how long the bus calls took
    task automatic count_rst(input int conv_0, input int mode_0,
                             output int conv_n, output int mode_n);
        int n;
        for (n = 0; n < 60; n++) begin
            if (dsp_rst !== conv_rst) begin
                cmp("dsp_rst", {7'h00, conv_rst}, {7'h00, dsp_rst});
            end
            @(negedge ref_clk);
        end
        conv_n = conv_tot - conv_0;
        mode_n = mode_tot - mode_0;
    endtask : count_rst

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int c_n;
        int m_n;
        int c_0;
        int m_0;
        miscompares = 0;
        comparisons = 0;
        rst_n   = 1'b0;
        err_pin = 1'b0;
        reg_req = '0;
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);

        // defaults, and an unmapped place that reads zero and ignores writes
        wait_pwr(RPC_RUN, 3'b111);
        rd("reset_request_control", RPC_RST_CTL_ADDR, RPC_RST_CTL_RST);
        rd("power_state_request", RPC_PWR_REQ_ADDR, RPC_PWR_REQ_RST);
        wr(8'h05, 8'hFF);
        rd("unmapped", 8'h05, 8'h00);
        rd("power_state_request", RPC_PWR_REQ_ADDR, 8'h00);
        $display("test defaults done");

        // both reset requests are refused while running
        c_0 = conv_tot;
        m_0 = mode_tot;
        wr(RPC_RST_CTL_ADDR, 8'h11);
        count_rst(c_0, m_0, c_n, m_n);
        cmp("conv_rst cycles", 8'h00, c_n[7:0]);
        cmp("mode_reg_rst cycles", 8'h00, m_n[7:0]);
        $display("test refused in run done");

        // standby keeps charge pump and digital supply only
        wr(RPC_PWR_REQ_ADDR, 8'h10);
        wait_pwr(RPC_STBY, 3'b011);
        rd("power_state_request", RPC_PWR_REQ_ADDR, 8'h10);
        $display("test standby done");

        // module reset: fixed pulse on both outputs, bit clears afterwards
        c_0 = conv_tot;
        m_0 = mode_tot;
        wr(RPC_RST_CTL_ADDR, 8'h10);
        rd("reset busy", RPC_RST_CTL_ADDR, 8'h10);
        count_rst(c_0, m_0, c_n, m_n);
        cmp("conv_rst cycles", 8'(RPC_MOD_RST_CYC), c_n[7:0]);
        rd("reset_request_control", RPC_RST_CTL_ADDR, 8'h00);
        $display("test module reset done");

        // both requests in one write in standby: both act, then running again
        c_0 = conv_tot;
        m_0 = mode_tot;
        wr(RPC_RST_CTL_ADDR, 8'h11);
        count_rst(c_0, m_0, c_n, m_n);
        cmp("conv_rst cycles", 8'(RPC_MOD_RST_CYC), c_n[7:0]);
        cmp("mode_reg_rst cycles", 8'h01, m_n[7:0]);
        wait_pwr(RPC_RUN, 3'b111);
        $display("test combined reset done");

        // powerdown wins over standby, and alone
        wr(RPC_PWR_REQ_ADDR, 8'h11);
        wait_pwr(RPC_PDN, 3'b000);
        wr(RPC_PWR_REQ_ADDR, 8'h01);
        wait_pwr(RPC_PDN, 3'b000);
        $display("test powerdown done");

        // register reset in powerdown: one pulse, requests back to defaults
        c_0 = conv_tot;
        m_0 = mode_tot;
        wr(RPC_RST_CTL_ADDR, 8'h01);
        count_rst(c_0, m_0, c_n, m_n);
        cmp("mode_reg_rst cycles", 8'h01, m_n[7:0]);
        cmp("conv_rst cycles", 8'h00, c_n[7:0]);
        rd("power_state_request", RPC_PWR_REQ_ADDR, RPC_PWR_REQ_RST);
        rd("reset_request_control", RPC_RST_CTL_ADDR, 8'h00);
        wait_pwr(RPC_RUN, 3'b111);
        $display("test register reset done");

        // error level forces standby without touching the request register
        err_pin = 1'b1;
        wait_pwr(RPC_STBY, 3'b011);
        rd("power_state_request", RPC_PWR_REQ_ADDR, 8'h00);
        err_pin = 1'b0;
        wait_pwr(RPC_RUN, 3'b111);
        $display("test error standby done");
        results();
    end

    // watchdog against a hung sequence
    initial begin
        #(40 * 5000);
        $display("Error watchdog expected done seen hang");
        miscompares++;
        results();
    end
endmodule : tb_top
